// >>> ubm_defs.svh
// user break match unit: offsets, field positions, reset values, timing
`ifndef UBM_DEFS_SVH
`define UBM_DEFS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define UBM_OFF_ADDR_HI  8'h00
`define UBM_OFF_ADDR_LO  8'h04
`define UBM_OFF_MASK     8'h08
`define UBM_OFF_SELECT   8'h0c
`define UBM_OFF_STATUS   8'h10
`define UBM_OFF_CLEAR    8'h14
`define UBM_OFF_ENABLE   8'h18
`define UBM_OFF_PC       8'h1c

// ----------------------------------------------------------------
// cycle select fields
// ----------------------------------------------------------------
`define UBM_SEL_DMA      7
`define UBM_SEL_CPU      6
`define UBM_SEL_DATA     5
`define UBM_SEL_FETCH    4
`define UBM_SEL_WRITE    3
`define UBM_SEL_READ     2
`define UBM_SEL_SZ_HI    1
`define UBM_SEL_SZ_LO    0

// ----------------------------------------------------------------
// sizes, status bits, reset values, levels, timing
// ----------------------------------------------------------------
`define UBM_SZ_ANY       2'b00
`define UBM_SZ_WORD      2'b10
`define UBM_SZ_LONG      2'b11
`define UBM_ST_MATCH     0
`define UBM_ST_TAKEN     1
`define UBM_RST_HALF     16'h0000
`define UBM_RST_MASK     32'h0000_0000
`define UBM_RST_SELECT   8'h00
`define UBM_RST_EVT      2'b00
`define UBM_MAX_LEVEL    4'he
`define UBM_REQ_DELAY    2

`endif

// >>> ubm_pkg.sv
// user break match unit: shared types
`default_nettype none

package ubm_pkg;

    typedef enum logic [1:0] {
        UBM_IDLE = 2'b00,
        UBM_AERR = 2'b01,
        UBM_REQ  = 2'b10
    } ubm_state_t;

endpackage

`default_nettype wire

// >>> ubm_addr_cmp.sv
// user break match unit: masked address comparator
`timescale 1ns/1ps
`default_nettype none

module ubm_addr_cmp #(
    parameter int W = 32
) (
    // compared values
    input  wire logic [W-1:0] addr_i,
    input  wire logic [W-1:0] bar_i,
    input  wire logic [W-1:0] mask_i,
    // result
    output logic              hit_o
);

    // a set mask bit drops that address bit from the compare
    assign hit_o = (((addr_i ^ bar_i) & ~mask_i) == '0);

endmodule

`default_nettype wire

// >>> ubm_top.sv
// user break match unit: registers, bus cycle matcher, break request
//
// Chosen here: the Wishbone register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "ubm_defs.svh"


module ubm_top (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic             wb_ack_o,
    output logic [31:0]      wb_dat_o,
    // watched bus cycle
    input  wire logic        bus_valid_i,
    input  wire logic [31:0] bus_addr_i,
    input  wire logic        bus_dma_i,
    input  wire logic        bus_fetch_i,
    input  wire logic        bus_write_i,
    input  wire logic [1:0]  bus_size_i,
    input  wire logic        bus_dual_i,
    input  wire logic        branch_first_i,
    // interrupt controller side
    input  wire logic        aerr_done_i,
    input  wire logic [3:0]  interrupt_mask_level_i,
    input  wire logic        earlier_irq_i,
    output logic             ubreak_req_o,
    output logic             ubreak_exc_o,
    output logic             break_fetch_o,
    output logic [31:0]      break_pc_o,
    output logic             irq_o
);

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [15:0]         break_addr_high_reg;
    logic [15:0]         break_addr_low_reg;
    logic [31:0]         mask_reg;
    logic [7:0]          break_cycle_select_reg;
    logic [1:0]          sts_reg;
    logic [1:0]          en_reg;
    logic                ack_reg;
    logic [31:0]         dat_reg;
    logic                stg_reg;
    logic [31:0]         stg_pc_reg;
    logic                stg_fetch_reg;
    logic                stg_odd_reg;
    ubm_pkg::ubm_state_t state_reg;
    ubm_pkg::ubm_state_t state_next;
    logic [31:0]         pc_reg;
    logic                fetch_reg;
    logic                req_reg;
    logic                exc_reg;
    logic                irq_reg;

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    wire        wb_req  = wb_cyc_i & wb_stb_i;
    // writes land on the edge that sees ack high, as the master expects
    wire        wb_wr   = wb_req & wb_we_i & ack_reg;
    wire [31:0] wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                           {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire [31:0] wdat    = wb_dat_i & wmask;
    wire        we_hi   = wb_wr & (wb_adr_i == `UBM_OFF_ADDR_HI);
    wire        we_lo   = wb_wr & (wb_adr_i == `UBM_OFF_ADDR_LO);
    wire        we_mask = wb_wr & (wb_adr_i == `UBM_OFF_MASK);
    wire        we_sel  = wb_wr & (wb_adr_i == `UBM_OFF_SELECT);
    wire        we_clr  = wb_wr & (wb_adr_i == `UBM_OFF_CLEAR);
    wire        we_en   = wb_wr & (wb_adr_i == `UBM_OFF_ENABLE);

    wire [15:0] hi_next   = (break_addr_high_reg & ~wmask[15:0]) | wdat[15:0];
    wire [15:0] lo_next   = (break_addr_low_reg & ~wmask[15:0]) | wdat[15:0];
    wire [31:0] mask_next = (mask_reg & ~wmask) | wdat;
    wire [7:0]  sel_next  = (break_cycle_select_reg & ~wmask[7:0]) | wdat[7:0];
    wire [1:0]  en_next   = (en_reg & ~wmask[1:0]) | wdat[1:0];

    logic [31:0] rd_data;

    always_comb begin
        if (wb_adr_i == `UBM_OFF_ADDR_HI) begin
            rd_data = {16'h0000, break_addr_high_reg};
        end else if (wb_adr_i == `UBM_OFF_ADDR_LO) begin
            rd_data = {16'h0000, break_addr_low_reg};
        end else if (wb_adr_i == `UBM_OFF_MASK) begin
            rd_data = mask_reg;
        end else if (wb_adr_i == `UBM_OFF_SELECT) begin
            rd_data = {24'h00_0000, break_cycle_select_reg};
        end else if (wb_adr_i == `UBM_OFF_STATUS) begin
            rd_data = {30'h0, sts_reg};
        end else if (wb_adr_i == `UBM_OFF_ENABLE) begin
            rd_data = {30'h0, en_reg};
        end else if (wb_adr_i == `UBM_OFF_PC) begin
            rd_data = pc_reg;
        end else begin
            rd_data = 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // cycle matcher
    // ----------------------------------------------------------------
    wire [7:0]  bcs     = break_cycle_select_reg;
    wire [31:0] bar     = {break_addr_high_reg, break_addr_low_reg};
    wire [31:0] addr_nx = bus_addr_i + 32'h0000_0002;
    wire        hit0;
    wire        hit1;

    ubm_addr_cmp #(.W(32)) u_cmp_first (
        .addr_i (bus_addr_i),
        .bar_i  (bar),
        .mask_i (mask_reg),
        .hit_o  (hit0)
    );

    ubm_addr_cmp #(.W(32)) u_cmp_second (
        .addr_i (addr_nx),
        .bar_i  (bar),
        .mask_i (mask_reg),
        .hit_o  (hit1)
    );

    // dma never fetches, fetches are never writes
    wire       fetch_eff = bus_fetch_i & ~bus_dma_i;
    wire       wr_eff    = bus_write_i & ~fetch_eff;
    wire [1:0] size_eff  = fetch_eff ? `UBM_SZ_WORD : bus_size_i;
    wire       pairs_ok  = (|bcs[7:6]) & (|bcs[5:4]) & (|bcs[3:2]);
    wire       src_ok    = bus_dma_i ? bcs[`UBM_SEL_DMA]
                                     : bcs[`UBM_SEL_CPU];
    wire       id_ok     = fetch_eff ? bcs[`UBM_SEL_FETCH]
                                     : bcs[`UBM_SEL_DATA];
    wire       rw_ok     = wr_eff ? bcs[`UBM_SEL_WRITE]
                                  : bcs[`UBM_SEL_READ];
    wire       sz_ok     = (bcs[1:0] == `UBM_SZ_ANY)
                         | (bcs[1:0] == size_eff);
    // odd fetch only exists as a branch target that faults
    wire       fetch_al  = ~bus_addr_i[0] | branch_first_i;
    wire       data_al   = ~((bus_size_i == `UBM_SZ_WORD) & bus_addr_i[0])
                         & ~((bus_size_i == `UBM_SZ_LONG)
                             & (|bus_addr_i[1:0]));
    wire       align_ok  = fetch_eff ? fetch_al : data_al;
    // second instruction of a paired fetch has its own address
    wire       hit_pair  = bus_dual_i & fetch_eff & hit1;
    wire       addr_ok   = hit0 | hit_pair;
    wire       cyc_hit   = bus_valid_i & pairs_ok & src_ok & id_ok
                         & rw_ok & sz_ok & align_ok & addr_ok;
    wire [31:0] hit_pc   = hit0 ? bus_addr_i : addr_nx;

    // ----------------------------------------------------------------
    // request sequencing
    // ----------------------------------------------------------------
    wire lvl_ok = (interrupt_mask_level_i <= `UBM_MAX_LEVEL);
    // an interrupt already in flight goes first
    wire take   = req_reg & lvl_ok & ~earlier_irq_i;
    wire [1:0] evt = {take, stg_reg};
    wire [1:0] clr = we_clr ? wdat[1:0] : 2'b00;
    wire [1:0] sts_next = (sts_reg & ~clr) | evt;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ubm_pkg::UBM_IDLE: begin
                if (stg_reg && stg_fetch_reg && stg_odd_reg) begin
                    state_next = ubm_pkg::UBM_AERR;
                end else if (stg_reg) begin
                    state_next = ubm_pkg::UBM_REQ;
                end
            end
            ubm_pkg::UBM_AERR: begin
                if (aerr_done_i) begin
                    state_next = ubm_pkg::UBM_REQ;
                end
            end
            ubm_pkg::UBM_REQ: begin
                if (take) begin
                    state_next = ubm_pkg::UBM_IDLE;
                end
            end
            default: begin
                state_next = ubm_pkg::UBM_IDLE;
            end
        endcase
    end

    wire capture = (state_reg == ubm_pkg::UBM_IDLE) & stg_reg;

    // ----------------------------------------------------------------
    // bus slave flops
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= wb_req & ~ack_reg;
            dat_reg <= rd_data;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            break_addr_high_reg    <= `UBM_RST_HALF;
            break_addr_low_reg     <= `UBM_RST_HALF;
            mask_reg               <= `UBM_RST_MASK;
            break_cycle_select_reg <= `UBM_RST_SELECT;
            en_reg                 <= `UBM_RST_EVT;
            sts_reg                <= `UBM_RST_EVT;
            irq_reg                <= 1'b0;
        end else begin
            if (we_hi) begin
                break_addr_high_reg <= hi_next;
            end
            if (we_lo) begin
                break_addr_low_reg <= lo_next;
            end
            if (we_mask) begin
                mask_reg <= mask_next;
            end
            if (we_sel) begin
                break_cycle_select_reg <= sel_next;
            end
            if (we_en) begin
                en_reg <= en_next;
            end
            sts_reg <= sts_next;
            irq_reg <= |(sts_reg & en_reg);
        end
    end

    // ----------------------------------------------------------------
    // match pipeline and request
    // ----------------------------------------------------------------
    // the stage latches the cycle, so later register writes cannot undo it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stg_reg       <= 1'b0;
            stg_pc_reg    <= 32'h0000_0000;
            stg_fetch_reg <= 1'b0;
            stg_odd_reg   <= 1'b0;
        end else begin
            stg_reg       <= cyc_hit;
            stg_pc_reg    <= hit_pc;
            stg_fetch_reg <= fetch_eff;
            stg_odd_reg   <= bus_addr_i[0];
        end
    end

    // one break outstanding; later matches only mark status
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= ubm_pkg::UBM_IDLE;
            pc_reg    <= 32'h0000_0000;
            fetch_reg <= 1'b0;
            req_reg   <= 1'b0;
            exc_reg   <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (capture) begin
                pc_reg    <= stg_pc_reg;
                fetch_reg <= stg_fetch_reg;
            end
            req_reg <= (state_next == ubm_pkg::UBM_REQ);
            exc_reg <= take;
        end
    end

    assign wb_ack_o      = ack_reg;
    assign wb_dat_o      = dat_reg;
    assign ubreak_req_o  = req_reg;
    assign ubreak_exc_o  = exc_reg;
    assign break_fetch_o = fetch_reg;
    assign break_pc_o    = pc_reg;
    assign irq_o         = irq_reg;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_caught;
        cyc_hit && state_reg == ubm_pkg::UBM_IDLE && !stg_reg && !aerr_done_i;
    endsequence

    sequence s_raised;
        stg_reg ##1 (state_reg != ubm_pkg::UBM_IDLE);
    endsequence

    pipe_delay_a: assert property (s_caught |=> s_raised)
        else $error("match did not advance to request");

    // a request straight from idle must trace back to a match two samples earlier
    req_late_a: assert property (
        $rose(req_reg) && $past(state_reg) == ubm_pkg::UBM_IDLE
        |-> $past(cyc_hit, 2))
        else $error("request rose without a match two cycles before");

    zero_pair_a: assert property (
        bcs[7:6] == 2'b00 || bcs[5:4] == 2'b00 || bcs[3:2] == 2'b00
        |=> !stg_reg)
        else $error("match with a disabled select pair");

    fetch_write_a: assert property (
        fetch_eff && bcs[3:2] == 2'b10 |-> !cyc_hit)
        else $error("fetch matched write-only select");

    dma_fetch_a: assert property (
        bus_dma_i && bcs[5:4] == 2'b01 |-> !cyc_hit)
        else $error("dma cycle matched fetch-only select");

    odd_word_a: assert property (
        !fetch_eff && bus_size_i == `UBM_SZ_WORD && bus_addr_i[0]
        |-> !cyc_hit)
        else $error("word access matched odd address");

    aerr_hold_a: assert property (
        state_reg == ubm_pkg::UBM_AERR && !aerr_done_i
        |=> !req_reg)
        else $error("request before address error done");

    level_gate_a: assert property (
        req_reg && interrupt_mask_level_i == 4'hf |=> req_reg && !exc_reg)
        else $error("break taken at mask level 15");

    earlier_first_a: assert property (
        req_reg && earlier_irq_i |=> !exc_reg)
        else $error("break taken ahead of earlier interrupt");

    pc_hold_a: assert property (
        capture ##1 (req_reg && !take)[*2] |-> pc_reg == $past(stg_pc_reg, 2))
        else $error("saved break address changed");

endmodule

`default_nettype wire

// >>> ubm_bus_model.sv
// model of the bus masters and interrupt controller around the unit
`timescale 1ns/1ps
`default_nettype none

module ubm_bus_model (
    // clock
    input  wire logic        clk_i,
    // watched bus cycle, kind is {first, dma, fetch, write, size, dual}
    output logic             valid_o,
    output logic [31:0]      addr_o,
    output logic [6:0]       kind_o,
    // interrupt controller
    output logic             aerr_done_o,
    output logic [3:0]       level_o,
    output logic             earlier_o
);
    initial begin
        valid_o = 1'b0;
        addr_o = 32'h0;
        kind_o = 7'h0;
        aerr_done_o = 1'b0;
        level_o = 4'hf;
        earlier_o = 1'b0;
    end

    // ----------
    // bus cycles
    // ----------
    // back-to-back calls give back-to-back cycles
    task automatic cycle(input logic [31:0] a, input logic [6:0] k);
        logic f;
        f = k[4] & ~k[5]; // dma never fetches
        @(posedge clk_i);
        valid_o <= 1'b1;
        addr_o <= a;
        kind_o <= f ? {k[6:5], 4'ha, k[0]} : {k[6:5], 1'b0, k[3:0]}; // word read
    endtask

    // released lines show the inverse, never the stale value
    task automatic release_bus();
        @(posedge clk_i);
        valid_o <= 1'b0;
        addr_o <= ~addr_o;
        kind_o <= ~kind_o;
    endtask

    task automatic set_intc(input logic [3:0] lvl, input logic early);
        @(posedge clk_i);
        level_o <= lvl;
        earlier_o <= early;
    endtask

    task automatic pulse_aerr();
        @(posedge clk_i);
        aerr_done_o <= 1'b1;
        @(posedge clk_i);
        aerr_done_o <= 1'b0;
    endtask
endmodule

`default_nettype wire

// >>> user_break_match_unit_test.sv
// self-checking bench for the user break match unit
`timescale 1ns/1ps
`default_nettype none
`include "ubm_defs.svh"

module user_break_match_unit_test;
    logic         clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0]   wb_adr_i;
    logic [31:0]  wb_dat_i, wb_dat_o, rd_val, break_pc_o, bus_addr_i;
    logic         bus_valid_i, aerr_done_i, earlier_irq_i, ubreak_req_o, ubreak_exc_o;
    logic         break_fetch_o, irq_o;
    logic [6:0]   kind;
    logic [3:0]   level;
    logic [119:0] case_tab [11];
    int           bad_count, n_compared;
    int           cyc_count = 0;

    ubm_top DUT (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i),
        .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .bus_valid_i(bus_valid_i),
        .bus_addr_i(bus_addr_i), .bus_dma_i(kind[5]), .bus_fetch_i(kind[4]),
        .bus_write_i(kind[3]), .bus_size_i(kind[2:1]), .bus_dual_i(kind[0]),
        .branch_first_i(kind[6]), .aerr_done_i(aerr_done_i),
        .interrupt_mask_level_i(level), .earlier_irq_i(earlier_irq_i),
        .ubreak_req_o(ubreak_req_o), .ubreak_exc_o(ubreak_exc_o),
        .break_fetch_o(break_fetch_o), .break_pc_o(break_pc_o), .irq_o(irq_o)
    );

    ubm_bus_model bm (
        .clk_i(clk_i), .valid_o(bus_valid_i), .addr_o(bus_addr_i), .kind_o(kind),
        .aerr_done_o(aerr_done_i), .level_o(level), .earlier_o(earlier_irq_i)
    );

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    // ----------
    // tasks
    // ----------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // request held until ack is sampled high, released after that edge
    task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        // no fixed wait count: only the bench timeout ends a hung transfer
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        rd_val = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic wb_wr(input logic [7:0] a, input logic [31:0] d);
        wb_xfer(1'b1, a, d);
    endtask

    task automatic wb_rd(input logic [7:0] a, input logic [31:0] exp);
        wb_xfer(1'b0, a, 32'h0);
        check($sformatf("reg %h", a), rd_val, exp);
    endtask

    task automatic setup(input logic [31:0] hi, lo, sel, msk);
        wb_wr(`UBM_OFF_ADDR_HI, hi);
        wb_wr(`UBM_OFF_ADDR_LO, lo);
        wb_wr(`UBM_OFF_MASK, msk);
        wb_wr(`UBM_OFF_SELECT, sel);
        wb_wr(`UBM_OFF_CLEAR, 32'h3);
    endtask

    task automatic take_break();
        repeat (3) @(posedge clk_i);
        #1;
        check("req held at level 15", {31'h0, ubreak_req_o}, 32'h1);
        bm.set_intc(4'he, 1'b1);
        repeat (2) @(posedge clk_i);
        #1;
        check("req behind other irq", {30'h0, ubreak_exc_o, ubreak_req_o}, 32'h1);
        bm.set_intc(4'he, 1'b0);
        @(posedge clk_i);
        #1;
        check("break taken", {30'h0, ubreak_exc_o, ubreak_req_o}, 32'h2);
        bm.set_intc(4'hf, 1'b0);
        wb_rd(`UBM_OFF_STATUS, 32'h3);
    endtask

    task automatic expect_req(input logic [31:0] pc);
        int n;
        n = 0;
        while (ubreak_req_o !== 1'b1 && n < 8) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        check("late req", {31'h0, ubreak_req_o}, 32'h1);
        check("late pc", break_pc_o, pc);
        take_break();
    endtask

    // one table line: {hi, lo, select, mask, address, kind, hit}
    task automatic run_case(input logic [119:0] c);
        setup({16'h0, c[119:104]}, {16'h0, c[103:88]}, {24'h0, c[87:80]}, c[79:48]);
        bm.cycle(c[47:16], c[14:8]);
        bm.release_bus();
        #1;
        check("req one cycle on", {31'h0, ubreak_req_o}, 32'h0);
        @(posedge clk_i);
        #1;
        check("req two cycles on", {31'h0, ubreak_req_o}, {31'h0, c[0]});
        wb_rd(`UBM_OFF_STATUS, {31'h0, c[0]});
        if (c[0]) begin
            check("break pc", break_pc_o, c[47:16]);
            check("fetch flag", {31'h0, break_fetch_o}, {31'h0, c[12]});
            take_break();
        end
    endtask

    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ----------
    // sequence
    // ----------
    always @(posedge clk_i) begin
        cyc_count++;
        if (cyc_count > 20000) begin
            bad_count++;
            end_of_test();
        end
    end

    initial begin
        rst_i = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_dat_i = 32'h0;
        bad_count = 0;
        n_compared = 0;
        case_tab = '{
            {16'h0000, 16'h0404, 8'h54, 32'h0, 32'h00000404, 8'h14, 8'h1},
            {16'h0015, 16'h389c, 8'h58, 32'h0, 32'h0015389c, 8'h14, 8'h0},
            {16'h0003, 16'h0147, 8'h54, 32'h0, 32'h00030147, 8'h14, 8'h0},
            {16'h0012, 16'h3456, 8'h6a, 32'h0, 32'h00123456, 8'h0c, 8'h1},
            {16'h00a8, 16'h0391, 8'h66, 32'h0, 32'h00a80391, 8'h04, 8'h0},
            {16'h0076, 16'hbcdc, 8'ha7, 32'h0, 32'h0076bcdc, 8'h26, 8'h1},
            {16'h0023, 16'h45c8, 8'h94, 32'h0, 32'h002345c8, 8'h34, 8'h0},
            {16'h0012, 16'h3456, 8'h4f, 32'h0, 32'h00123456, 8'h06, 8'h0},
            {16'h0012, 16'h3456, 8'h69, 32'h0, 32'h00123456, 8'h0c, 8'h0},
            {16'h0012, 16'h3400, 8'h6e, 32'hff, 32'h00123456, 8'h0c, 8'h1},
            {16'h0012, 16'h3400, 8'h6e, 32'h0f, 32'h00123456, 8'h0c, 8'h0}
        };
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        check("outputs after reset", {29'h0, ubreak_req_o, irq_o, wb_ack_o}, 32'h0);
        for (int i = 0; i < 9; i++) begin
            wb_rd(8'(i * 4), 32'h0);
        end
        wb_rd(8'h02, 32'h0);
        wb_wr(`UBM_OFF_ADDR_HI, 32'hffff1234);
        wb_rd(`UBM_OFF_ADDR_HI, 32'h00001234);
        wb_wr(`UBM_OFF_SELECT, 32'hffffffff);
        wb_rd(`UBM_OFF_SELECT, 32'h000000ff);
        wb_wr(`UBM_OFF_STATUS, 32'hff);
        wb_rd(`UBM_OFF_STATUS, 32'h0);
        for (int i = 0; i < 11; i++) begin
            run_case(case_tab[i]);
        end
        setup(32'h3, 32'h0147, 32'h54, 32'h0);
        bm.cycle(32'h00030147, 7'h54);
        bm.release_bus();
        repeat (4) @(posedge clk_i);
        #1;
        check("held for address error", {31'h0, ubreak_req_o}, 32'h0);
        bm.pulse_aerr();
        expect_req(32'h00030147);
        setup(32'h0, 32'h1002, 32'h54, 32'h0);
        bm.cycle(32'h00001000, 7'h15);
        bm.release_bus();
        wb_wr(`UBM_OFF_ADDR_LO, 32'h0);
        expect_req(32'h00001002);
        setup(32'h0, 32'h2004, 32'h54, 32'h0);
        bm.cycle(32'h00002000, 7'h14);
        bm.cycle(32'h00002002, 7'h14);
        bm.cycle(32'h00002004, 7'h14);
        bm.cycle(32'h00003000, 7'h14);
        bm.release_bus();
        expect_req(32'h00002004);
        run_case(case_tab[0]);
        check("irq while disabled", {31'h0, irq_o}, 32'h0);
        wb_wr(`UBM_OFF_ENABLE, 32'h2);
        repeat (2) @(posedge clk_i);
        #1;
        check("irq raised", {31'h0, irq_o}, 32'h1);
        wb_wr(`UBM_OFF_CLEAR, 32'h2);
        repeat (2) @(posedge clk_i);
        #1;
        check("irq cleared", {31'h0, irq_o}, 32'h0);
        wb_rd(`UBM_OFF_STATUS, 32'h1);
        end_of_test();
    end
endmodule

`default_nettype wire
